// file: hdl/typec_cc_defines.vh
// constants for the type-c configuration-channel role controller
`ifndef TYPEC_CC_DEFINES_VH
`define TYPEC_CC_DEFINES_VH

// register offset and field positions
`define REG_ROLE_TERM_CTRL 8'h0a
`define FLD_TERM_DISABLE 0
`define FLD_ROLE_SEL_LO 4
`define FLD_ROLE_SEL_HI 5
`define FLD_ADV_LEVEL_LO 6
`define FLD_ADV_LEVEL_HI 7
`define ROLE_TERM_CTRL_RESET 8'h00

// strap levels
`define STRAP_LOW 2'h0
`define STRAP_HIGH 2'h1
`define STRAP_FLOAT 2'h2

// role codes
`define ROLE_DRP 2'h0
`define ROLE_SINK 2'h1
`define ROLE_SOURCE 2'h2

// cc line states seen by the comparators
`define CC_OPEN 2'h0
`define CC_RD 2'h1
`define CC_RA 2'h2
`define CC_RP 2'h3

// current advertisement levels
`define ADV_DEFAULT 2'h0
`define ADV_MID 2'h1
`define ADV_HIGH 2'h2

// termination codes on the cc pins
`define TERM_NONE 2'h0
`define TERM_RD 2'h1
`define TERM_RP 2'h2

// timing
`define DEBOUNCE_US 100
`define DRP_HALF_US 35
`define CLK_MHZ 50

`endif

// file: hdl/cc_line_debounce.v
// debounce filter for one configuration-channel line state
`default_nettype none
module cc_line_debounce #(
    parameter integer COUNT = 5000,
    parameter integer CW = 16
) (
    input wire core_clk,
    input wire rst,
    input wire [1:0] raw,
    output reg [1:0] stable
);
    reg [1:0] last;
    reg [CW-1:0] cnt;

    always @(posedge core_clk) begin
        if (rst) begin
            last <= 2'h0;
            cnt <= {CW{1'b0}};
            stable <= 2'h0;
        end else if (raw != last) begin
            last <= raw;
            cnt <= {CW{1'b0}};
        end else if (cnt == COUNT[CW-1:0] - 1'b1) begin
            stable <= last;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: hdl/typec_cc_role_controller.v
// type-c cc role controller: role strap, terminations, attach, vconn and orientation
//
// Overview of operation
// - the three-level role strap picks source on high, sink on low, dual role on float.
// - the strap is caught once after reset and its role is held until the next reset.
// - try modes exist only in dual role, vbus and current detection only as sink, vconn and advertisement only as source.
// - a source-only port keeps rp on both cc lines except while idle or with terminations disabled.
// - a source first advertises default current, then moves rp to the selected higher level.
// - once attached as source with rd seen, the open-drain sink-attached pin is pulled low.
// - with a sink attached and ra on the other cc pin, vconn goes onto that other pin.
// - with the strap floating, writing the source code into the role field gives source-only role.
// - cable orientation drives the select of the two-channel 2:1 superspeed mux.
// - the orientation also appears on its own open-drain output.
// - no power delivery messaging is done on the cc lines.
`default_nettype none
`include "typec_cc_defines.vh"
module typec_cc_role_controller #(
    parameter integer DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ,
    parameter integer DRP_HALF_CYCLES = `DRP_HALF_US * `CLK_MHZ,
    parameter integer CW = 16
) (
    input wire core_clk,
    input wire rst,
    input wire [1:0] role_strap,
    input wire [1:0] adv_strap,
    input wire [1:0] cc1_state,
    input wire [1:0] cc2_state,
    input wire vbus_present,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg [1:0] cc1_term,
    output reg [1:0] cc2_term,
    output reg [1:0] rp_level,
    output reg vconn_cc1_en,
    output reg vconn_cc2_en,
    output reg sink_attached_n_oe,
    output reg sink_attached_n_o,
    output reg orient_oe,
    output reg orient_o,
    output reg ss_mux_sel,
    output reg mux_enable,
    output reg try_enable,
    output reg vbus_detect_en,
    output reg current_detect_en
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_UNATTACHED = 3'h1;
    localparam [2:0] ST_ATTACH_WAIT_SRC = 3'h2;
    localparam [2:0] ST_ATTACHED_SRC = 3'h3;
    localparam [2:0] ST_ATTACH_WAIT_SNK = 3'h4;
    localparam [2:0] ST_ATTACHED_SNK = 3'h5;

    reg strap_taken;
    reg [1:0] strap_role;
    reg [7:0] ctrl;
    reg [2:0] state;
    reg [2:0] next_state;
    reg presenting_src;
    reg [CW-1:0] drp_cnt;
    reg flip;
    reg next_flip;
    reg attached_adv;
    wire [3:0] cc_raw = {cc2_state, cc1_state};
    wire [3:0] cc_db;
    wire [1:0] cc1_db = cc_db[1:0];
    wire [1:0] cc2_db = cc_db[3:2];
    wire term_disable = ctrl[`FLD_TERM_DISABLE];
    wire [1:0] role_sel = ctrl[`FLD_ROLE_SEL_HI:`FLD_ROLE_SEL_LO];
    wire [1:0] adv_sel = ctrl[`FLD_ADV_LEVEL_HI:`FLD_ADV_LEVEL_LO];
    reg [1:0] role;
    reg [1:0] adv_target;

    // one filter per cc line
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_db
            cc_line_debounce #(
                .COUNT(DEBOUNCE_CYCLES),
                .CW(CW)
            ) u_db (
                .core_clk(core_clk),
                .rst(rst),
                .raw(cc_raw[gi*2 +: 2]),
                .stable(cc_db[gi*2 +: 2])
            );
        end
    endgenerate

    // strap taken by a clocked process on the first edge after release
    always @(posedge core_clk) begin
        if (rst) begin
            strap_taken <= 1'b0;
            strap_role <= `ROLE_DRP;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            case (role_strap)
                `STRAP_HIGH: strap_role <= `ROLE_SOURCE;
                `STRAP_LOW: strap_role <= `ROLE_SINK;
                default: strap_role <= `ROLE_DRP;
            endcase
        end
    end

    // effective role: the register only overrides a floating strap
    always @* begin
        role = strap_role;
        if (strap_role == `ROLE_DRP && role_sel != `ROLE_DRP) begin
            role = role_sel;
        end
    end

    // strap wins unless software picked a higher level
    always @* begin
        adv_target = (adv_sel > adv_strap) ? adv_sel : adv_strap;
        if (adv_target > `ADV_HIGH) begin
            adv_target = `ADV_HIGH;
        end
    end

    // register port
    always @(posedge core_clk) begin
        if (rst) begin
            ctrl <= `ROLE_TERM_CTRL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `REG_ROLE_TERM_CTRL) begin
                ctrl <= reg_wdata;
            end
            if (reg_rd) begin
                if (reg_addr == `REG_ROLE_TERM_CTRL) begin
                    reg_rdata <= ctrl;
                end else begin
                    // unmapped reads show the live connection status
                    reg_rdata <= {2'h0, flip, state, role};
                end
            end
        end
    end

    // dual role alternates presentation between rp and rd
    always @(posedge core_clk) begin
        if (rst) begin
            drp_cnt <= {CW{1'b0}};
            presenting_src <= 1'b0;
        end else if (role == `ROLE_SOURCE) begin
            presenting_src <= 1'b1;
            drp_cnt <= {CW{1'b0}};
        end else if (role == `ROLE_SINK) begin
            presenting_src <= 1'b0;
            drp_cnt <= {CW{1'b0}};
        end else if (state == ST_UNATTACHED) begin
            if (drp_cnt == DRP_HALF_CYCLES[CW-1:0] - 1'b1) begin
                drp_cnt <= {CW{1'b0}};
                presenting_src <= ~presenting_src;
            end else begin
                drp_cnt <= drp_cnt + 1'b1;
            end
        end
    end

    // connection state machine; no pd messages are ever sent
    always @* begin
        next_state = state;
        next_flip = flip;
        case (state)
            ST_IDLE: begin
                if (strap_taken && !term_disable) begin
                    next_state = ST_UNATTACHED;
                end
            end
            ST_UNATTACHED: begin
                if (presenting_src && (cc1_db == `CC_RD || cc2_db == `CC_RD)) begin
                    next_state = ST_ATTACH_WAIT_SRC;
                end else if (!presenting_src && (cc1_db == `CC_RP || cc2_db == `CC_RP)) begin
                    next_state = ST_ATTACH_WAIT_SNK;
                end
            end
            ST_ATTACH_WAIT_SRC: begin
                if (cc1_db == `CC_RD) begin
                    next_flip = 1'b0;
                    next_state = ST_ATTACHED_SRC;
                end else if (cc2_db == `CC_RD) begin
                    next_flip = 1'b1;
                    next_state = ST_ATTACHED_SRC;
                end else begin
                    next_state = ST_UNATTACHED;
                end
            end
            ST_ATTACHED_SRC: begin
                if (cc1_db != `CC_RD && cc2_db != `CC_RD) begin
                    next_state = ST_UNATTACHED;
                end
            end
            ST_ATTACH_WAIT_SNK: begin
                // a sink only attaches once vbus is up
                if (cc1_db != `CC_RP && cc2_db != `CC_RP) begin
                    next_state = ST_UNATTACHED;
                end else if (vbus_present) begin
                    next_flip = (cc2_db == `CC_RP);
                    next_state = ST_ATTACHED_SNK;
                end
            end
            ST_ATTACHED_SNK: begin
                if (!vbus_present) begin
                    next_state = ST_UNATTACHED;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (term_disable) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            flip <= 1'b0;
            attached_adv <= 1'b0;
        end else begin
            state <= next_state;
            flip <= next_flip;
            // advertisement is raised only after a full attach
            attached_adv <= (next_state == ST_ATTACHED_SRC);
        end
    end

    // outputs, all registered
    always @(posedge core_clk) begin
        if (rst) begin
            cc1_term <= `TERM_NONE;
            cc2_term <= `TERM_NONE;
            rp_level <= `ADV_DEFAULT;
            vconn_cc1_en <= 1'b0;
            vconn_cc2_en <= 1'b0;
            sink_attached_n_oe <= 1'b0;
            sink_attached_n_o <= 1'b0;
            orient_oe <= 1'b0;
            orient_o <= 1'b0;
            ss_mux_sel <= 1'b0;
            mux_enable <= 1'b0;
            try_enable <= 1'b0;
            vbus_detect_en <= 1'b0;
            current_detect_en <= 1'b0;
        end else begin
            if (term_disable || state == ST_IDLE) begin
                cc1_term <= `TERM_NONE;
                cc2_term <= `TERM_NONE;
            end else if (role == `ROLE_SOURCE || presenting_src) begin
                cc1_term <= `TERM_RP;
                cc2_term <= `TERM_RP;
            end else begin
                cc1_term <= `TERM_RD;
                cc2_term <= `TERM_RD;
            end
            rp_level <= attached_adv ? adv_target : `ADV_DEFAULT;
            // vconn only from the source side, onto the pin carrying ra
            vconn_cc1_en <= (state == ST_ATTACHED_SRC) && flip && (cc1_db == `CC_RA);
            vconn_cc2_en <= (state == ST_ATTACHED_SRC) && !flip && (cc2_db == `CC_RA);
            sink_attached_n_o <= 1'b0;
            sink_attached_n_oe <= (state == ST_ATTACHED_SRC);
            // orientation pin pulled low for cc1, released high for cc2
            orient_o <= 1'b0;
            orient_oe <= !flip;
            ss_mux_sel <= flip;
            mux_enable <= (state == ST_ATTACHED_SRC) || (state == ST_ATTACHED_SNK);
            // role is only meaningful once the strap is caught; avoids a dual-role blip
            try_enable <= strap_taken && (role == `ROLE_DRP);
            vbus_detect_en <= strap_taken && ((role == `ROLE_SINK) ||
                (role == `ROLE_DRP && !presenting_src));
            current_detect_en <= (state == ST_ATTACHED_SNK);
        end
    end
endmodule
`default_nettype wire

// file: testbench/typec_cc_props.sv
// concurrent checks on the cc role controller ports
`default_nettype none
`include "typec_cc_defines.vh"
module typec_cc_props (
    input wire core_clk,
    input wire rst,
    input wire [1:0] role_strap,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [1:0] cc1_term,
    input wire [1:0] cc2_term,
    input wire vconn_cc1_en,
    input wire vconn_cc2_en,
    input wire sink_attached_n_oe,
    input wire sink_attached_n_o,
    input wire orient_oe,
    input wire ss_mux_sel,
    input wire mux_enable,
    input wire try_enable,
    input wire vbus_detect_en,
    input wire current_detect_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_OD_LOW: assert property (sink_attached_n_o == 1'b0)
        else $error("attach pin driven high");
    AST_ATT_MUX: assert property (sink_attached_n_oe |-> mux_enable)
        else $error("attach flag without attach");
    AST_TERM_SYM: assert property (cc1_term == cc2_term)
        else $error("cc terminations differ");
    AST_VCONN_ONE: assert property (!(vconn_cc1_en && vconn_cc2_en))
        else $error("vconn on both lines");
    AST_VCONN_SIDE: assert property ((vconn_cc1_en || vconn_cc2_en) |->
        mux_enable && ss_mux_sel == vconn_cc1_en) else $error("vconn on wrong line");
    AST_ORIENT: assert property (mux_enable |-> orient_oe == !ss_mux_sel)
        else $error("orientation pin disagrees with mux");
    AST_SRC_ONLY: assert property ((vconn_cc1_en || vconn_cc2_en || sink_attached_n_oe)
        |-> !vbus_detect_en && !current_detect_en) else $error("sink detect as source");
    AST_TRY_DRP: assert property (try_enable |-> role_strap == `STRAP_FLOAT)
        else $error("try mode outside dual role");
    AST_TERM_OFF: assert property (reg_wr && reg_addr == `REG_ROLE_TERM_CTRL &&
        reg_wdata[`FLD_TERM_DISABLE] |-> ##2 cc1_term == `TERM_NONE ##1 !mux_enable)
        else $error("terminations kept while disabled");
    AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule
bind typec_cc_role_controller typec_cc_props u_props (.core_clk(core_clk), .rst(rst),
    .role_strap(role_strap), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cc1_term(cc1_term), .cc2_term(cc2_term),
    .vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en),
    .sink_attached_n_oe(sink_attached_n_oe), .sink_attached_n_o(sink_attached_n_o),
    .orient_oe(orient_oe), .ss_mux_sel(ss_mux_sel), .mux_enable(mux_enable),
    .try_enable(try_enable), .vbus_detect_en(vbus_detect_en),
    .current_detect_en(current_detect_en));
`default_nettype wire

// file: testbench/cc_partner_model.sv
// remote type-c port partner as seen through the cc comparators
`default_nettype none
`include "typec_cc_defines.vh"
module cc_partner_model (
    input wire logic [1:0] kind,
    input wire logic flip,
    input wire logic with_ra,
    input wire logic [1:0] cc1_term,
    input wire logic [1:0] cc2_term,
    output wire logic [1:0] cc1_state,
    output wire logic [1:0] cc2_state,
    output wire logic vbus_present
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] near;
    logic [1:0] far;
    // a pull only reads through the opposite pull; an unterminated line reads open
    function automatic logic [1:0] seen(input logic [1:0] term, input logic [1:0] v);
        if (v == `CC_RP) return (term == `TERM_RD) ? v : `CC_OPEN;
        return (term == `TERM_RP) ? v : `CC_OPEN;
    endfunction
    assign near = (kind == 2'h1) ? `CC_RD : (kind == 2'h2) ? `CC_RP : `CC_OPEN;
    assign far = (kind == 2'h1 && with_ra) ? `CC_RA : `CC_OPEN;
    assign cc1_state = seen(cc1_term, flip ? far : near);
    assign cc2_state = seen(cc2_term, flip ? near : far);
    assign vbus_present = (kind == 2'h2);
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// register-level bench for the cc role controller
`default_nettype none
`include "typec_cc_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] role_strap = `STRAP_HIGH;
    logic [1:0] adv_strap = `ADV_MID;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] kind = 2'h0;
    logic flip = 1'b0;
    logic with_ra = 1'b0;
    logic [1:0] cc1_state, cc2_state, cc1_term, cc2_term, rp_level;
    logic [7:0] reg_rdata, d;
    logic vbus_present, vconn_cc1_en, vconn_cc2_en, sink_attached_n_oe, sink_attached_n_o;
    logic orient_oe, orient_o, ss_mux_sel, mux_enable, try_enable, vbus_detect_en;
    logic current_detect_en;
    int n_mismatch = 0;
    int check_count = 0;
    always #10 core_clk = ~core_clk;
    // short debounce keeps attach within a few dozen cycles
    typec_cc_role_controller #(.DEBOUNCE_CYCLES(4), .DRP_HALF_CYCLES(8)) dut (
        .core_clk(core_clk), .rst(rst), .role_strap(role_strap), .adv_strap(adv_strap),
        .cc1_state(cc1_state), .cc2_state(cc2_state), .vbus_present(vbus_present),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .cc1_term(cc1_term), .cc2_term(cc2_term),
        .rp_level(rp_level), .vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en),
        .sink_attached_n_oe(sink_attached_n_oe), .sink_attached_n_o(sink_attached_n_o),
        .orient_oe(orient_oe), .orient_o(orient_o), .ss_mux_sel(ss_mux_sel),
        .mux_enable(mux_enable), .try_enable(try_enable), .vbus_detect_en(vbus_detect_en),
        .current_detect_en(current_detect_en));
    cc_partner_model partner (.kind(kind), .flip(flip), .with_ra(with_ra),
        .cc1_term(cc1_term), .cc2_term(cc2_term), .cc1_state(cc1_state),
        .cc2_state(cc2_state), .vbus_present(vbus_present));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the strap is only ever changed under reset, never while running
    task automatic reboot(input logic [1:0] s);
        @(posedge core_clk);
        rst <= 1'b1;
        role_strap <= s;
        kind <= 2'h0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        #1;
        v = reg_rdata;
    endtask
    task automatic plug(input logic [1:0] k, input logic f, input logic r);
        int i;
        @(posedge core_clk);
        kind <= k;
        flip <= f;
        with_ra <= r;
        for (i = 0; i < 300 && mux_enable !== (k != 2'h0); i++) begin
            @(posedge core_clk);
            #1;
        end
        repeat (3) @(posedge core_clk);
        #1;
        check(mux_enable, k != 2'h0);
    endtask
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        reboot(`STRAP_HIGH);
        rd(`REG_ROLE_TERM_CTRL, d);
        check(d, `ROLE_TERM_CTRL_RESET);
        check({cc1_term, cc2_term}, {`TERM_RP, `TERM_RP});
        check(rp_level, `ADV_DEFAULT);
        check(sink_attached_n_oe, 1'b0);
        plug(2'h1, 1'b0, 1'b1);
        check(sink_attached_n_oe, 1'b1);
        check({orient_o, sink_attached_n_o}, 2'b00);
        check({vconn_cc1_en, vconn_cc2_en}, 2'b01);
        check({ss_mux_sel, orient_oe}, 2'b01);
        check(rp_level, `ADV_MID);
        check({try_enable, vbus_detect_en, current_detect_en}, 3'b000);
        wr(`REG_ROLE_TERM_CTRL, 8'h80);
        check(rp_level, `ADV_HIGH);
        wr(8'h0b, 8'hff);
        rd(`REG_ROLE_TERM_CTRL, d);
        check(d, 8'h80);
        plug(2'h0, 1'b0, 1'b0);
        plug(2'h1, 1'b1, 1'b0);
        check({ss_mux_sel, orient_oe, vconn_cc1_en, vconn_cc2_en}, 4'b1000);
        reboot(`STRAP_LOW);
        check({cc1_term, cc2_term}, {`TERM_RD, `TERM_RD});
        plug(2'h2, 1'b1, 1'b0);
        check({vbus_detect_en, current_detect_en}, 2'b11);
        check({sink_attached_n_oe, vconn_cc1_en, vconn_cc2_en}, 3'b000);
        check(ss_mux_sel, 1'b1);
        reboot(`STRAP_FLOAT);
        check(try_enable, 1'b1);
        wr(`REG_ROLE_TERM_CTRL, 8'h01);
        check({cc1_term, cc2_term}, {`TERM_NONE, `TERM_NONE});
        wr(`REG_ROLE_TERM_CTRL, 8'h21);
        wr(`REG_ROLE_TERM_CTRL, 8'h20);
        rd(`REG_ROLE_TERM_CTRL, d);
        check(d, 8'h20);
        // a dual-role port would toggle within this span
        repeat (20) begin
            @(posedge core_clk);
            #1;
            check(cc1_term, `TERM_RP);
        end
        plug(2'h1, 1'b0, 1'b0);
        check(sink_attached_n_oe, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
